// [design/burst_ctrl_pkg.sv]
// Constants, register map and carrier types for the modem burst controller
package burst_ctrl_pkg;
	// Register addresses on the host serial control bus
	localparam logic [6:0][7:0] TX_ADDR = {8'hc7, 8'hc2, 8'hcb, 8'hca, 8'hb7, 8'hb6, 8'hb5};
	localparam logic [6:0][7:0] RX_ADDR = {8'hcc, 8'hc9, 8'hc5, 8'hbb, 8'hba, 8'hb9, 8'hb8};
	localparam logic [7:0] ADDR_RX_CTRL = 8'hc3;
	localparam logic [7:0] ADDR_MODE = 8'hc1;
	localparam logic [7:0] ADDR_STATUS = 8'hc6;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hce;
	// Serial frame: 8 address bits then 16 data bits
	localparam logic [4:0] ADDR_BITS = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	// Mode and control register fields
	localparam int MODE_TRIG_BIT = 2;
	localparam int MODE_FMT_BIT = 3;
	localparam int MODE_TEST_LSB = 4;
	localparam int MODE_SEQ_BIT = 6;
	localparam int MODE_TRIG_POL_BIT = 7;
	// Rx transfer control field
	localparam int RXC_FLOW_BIT = 8;
	// Low control byte of word 0: counter, unit count, bit/byte selector
	localparam int CTRL_CNT_LSB = 2;
	localparam int CTRL_UNIT_BIT = 7;
	// Status bits
	localparam int ST_PRG = 0;
	localparam int ST_READY = 1;
	localparam int ST_EVENT = 2;
	localparam int ST_CS_BUSY = 3;
	localparam int ST_CS_SYNC = 4;
	localparam int ST_CS_CLEAR = 5;
	localparam int ST_FSYNC = 6;
	localparam int ST_IRQ = 15;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
	localparam logic [15:0] RX_CTRL_RESET = 16'h0000;
	// Payload geometry
	localparam int PAYLOAD_BITS = 104;
	localparam logic [6:0] MAX_XFER_BITS = 7'h68;
	localparam logic [6:0] MIN_TIMED_BITS = 7'h08;
	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int CS_PERIOD_NS = 20000;
	localparam int RX_GAP_NS = 1000;
	localparam int CS_PERIOD_CYC = (CS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RX_GAP_CYC = (RX_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] CS_PERIOD_LOAD = 12'(CS_PERIOD_CYC);
	localparam logic [7:0] RX_GAP_LOAD = 8'(RX_GAP_CYC);
	localparam logic [7:0] XTAL_TRIG_DIV = 8'h10;
	// Carrier sense averaging window of eight samples
	localparam int CS_WIN_LOG2 = 3;
	localparam logic [7:0] CS_THRESHOLD = 8'h40;
	localparam logic [8:0] PRBS_SEED = 9'h1ff;

	typedef enum logic [1:0] {MODE_IDLE, MODE_RX, MODE_TX, MODE_CS} mode_t;
	typedef enum logic [1:0] {TEST_NONE, TEST_EYE, TEST_PRBS, TEST_PREAMBLE} test_t;
	typedef enum logic [2:0] {S_IDLE, S_RX_SEARCH, S_RX_DATA, S_TX_WAIT, S_CS_WAIT, S_CS_SENSE,
		S_TX_RUN} ctrl_state_t;

	// Host serial bus pins
	typedef struct packed {
		logic csN;
		logic sclk;
		logic sdi;
	} host_bus_in_t;

	// Feed from the demodulator
	typedef struct packed {
		logic bitValid;
		logic bitVal;
		logic syncFound;
		logic filtValid;
		logic [7:0] filtSample;
		logic rssiValid;
		logic [7:0] rssi;
	} rx_feed_t;

	// Feed to the modulator and transmit hardware
	typedef struct packed {
		logic bitValid;
		logic bitVal;
		logic rampOn;
		logic gpioOn;
	} tx_out_t;
endpackage

// [design/modem_burst_ctrl.sv]
// Burst control, payload transfer and host registers of the packet modem
`timescale 1ns/1ps

module modem_burst_ctrl
(
	input wire logic clk, // 200 MHz clock
	input wire logic reset_n, // Synchronous reset
	input wire burst_ctrl_pkg::host_bus_in_t hostIn, // Host serial bus pins
	output logic hostReplyData, // Serial read data
	output logic interruptRequestLineN, // Interrupt request
	input wire logic txTriggerPin, // External transmit trigger
	input wire burst_ctrl_pkg::rx_feed_t rxFeed, // Demodulator feed
	input wire logic modBitReq, // Modulator wants a bit
	output burst_ctrl_pkg::tx_out_t txOut, // Modulator feed
	output logic [7:0] modulatorOutputA, // First modulator output
	output logic modulatorOutputB // Second modulator output
);
	import burst_ctrl_pkg::*;

	typedef struct packed {
		logic [1:0] csS;
		logic [1:0] sclkS;
		logic [1:0] sdiS;
		logic [1:0] trigS;
		logic sclkPrev;
		logic [4:0] bitCnt;
		logic [7:0] addr;
		logic [15:0] shiftIn;
		logic [15:0] replyShift;
		logic replyOut;
		logic [6:0][15:0] txWords;
		logic [6:0][15:0] rxWords;
		logic [15:0] rxCtrl;
		logic [15:0] modeCtrl;
		logic [15:0] irqMask;
		logic [15:0] status;
		logic interrupt_request_line;
		ctrl_state_t st;
		logic [1:0] txTc;
		logic [103:0] txPend;
		logic [6:0] txPendBits;
		logic txPendValid;
		logic [103:0] txShift;
		logic [6:0] txLeft;
		logic [8:0] lfsr;
		logic preambleBit;
		tx_out_t tx;
		logic [103:0] asmData;
		logic [6:0] asmCnt;
		logic [6:0] xferBits;
		logic [5:0] rxUnitCtrl;
		logic [1:0][109:0] fifoData;
		logic fifoWr;
		logic fifoRd;
		logic [1:0] fifoCnt;
		logic [1:0] rxTc;
		logic [1:0] hostTc;
		logic credit;
		logic [7:0] gapCnt;
		logic [7:0][7:0] rssiWin;
		logic [10:0] rssiSum;
		logic [11:0] csTimer;
		logic [7:0] modA;
		logic modB;
		logic [7:0] xtalDiv;
	} state_t;

	state_t r;
	state_t n;

	// Bits carried by a transfer described by a control byte
	function automatic logic [6:0] sizeOf(input logic [7:0] ctrl);
		logic [6:0] cnt;
		logic [6:0] bits;
		cnt = {2'b00, ctrl[CTRL_CNT_LSB +: 5]};
		bits = ctrl[CTRL_UNIT_BIT] ? 7'(cnt << 3) : cnt;
		if (bits > MAX_XFER_BITS)
			bits = MAX_XFER_BITS;
		return bits;
	endfunction

	// Data bits 0-103 of a seven-word block
	function automatic logic [103:0] packBlock(input logic [6:0][15:0] w);
		return {w[6], w[5], w[4], w[3], w[2], w[1], w[0][15:8]};
	endfunction

	// Carrier sense period entry values
	function automatic logic [11:0] csStart();
		return CS_PERIOD_LOAD;
	endfunction

	logic sclkRise;
	logic sclkFall;
	logic [7:0] addrNow;
	logic [15:0] wrData;
	logic doWrite;
	logic clearFlags;
	logic [15:0] setBits;
	logic [15:0] readVal;
	logic flowOn;
	logic trigHit;
	logic modeChange;
	mode_t newMode;
	logic push;
	logic pop;
	logic [109:0] popEntry;
	logic [6:0] nextCnt;
	logic [10:0] avg;

	always_comb
	begin
		n = r;
		setBits = '0;
		doWrite = 1'b0;
		clearFlags = 1'b0;
		addrNow = {r.addr[6:0], r.sdiS[1]};
		wrData = {r.shiftIn[14:0], r.sdiS[1]};
		readVal = '0;
		push = 1'b0;
		pop = 1'b0;
		popEntry = r.fifoData[r.fifoRd];
		nextCnt = r.asmCnt + 7'h01;
		avg = r.rssiSum >> CS_WIN_LOG2;
		flowOn = r.rxCtrl[RXC_FLOW_BIT];
		trigHit = r.trigS[1] == r.modeCtrl[MODE_TRIG_POL_BIT];
		// Input synchronisers
		n.csS = {r.csS[0], hostIn.csN};
		n.sclkS = {r.sclkS[0], hostIn.sclk};
		n.sdiS = {r.sdiS[0], hostIn.sdi};
		n.trigS = {r.trigS[0], txTriggerPin};
		n.sclkPrev = r.sclkS[1];
		sclkRise = r.sclkS[1] & ~r.sclkPrev;
		sclkFall = ~r.sclkS[1] & r.sclkPrev;
		n.tx.bitValid = 1'b0;

		// Serial frame: address, then data in or out
		if (r.csS[1])
			n.bitCnt = '0;
		else if (sclkRise)
		begin
			if (r.bitCnt < ADDR_BITS)
				n.addr = addrNow;
			else
				n.shiftIn = wrData;
			if (r.bitCnt == ADDR_BITS - 5'h01)
			begin
				for (int k = 0; k < 7; k++)
					if (addrNow == RX_ADDR[k])
						readVal = r.rxWords[k];
				if (addrNow == ADDR_STATUS)
				begin
					readVal = r.status;
					readVal[ST_IRQ] = ~r.interrupt_request_line;
					clearFlags = 1'b1;
				end
				n.replyShift = readVal;
			end
			if (r.bitCnt == FRAME_BITS - 5'h01)
				doWrite = 1'b1;
			if (r.bitCnt != FRAME_BITS)
				n.bitCnt = r.bitCnt + 5'h01;
		end
		if (sclkFall && !r.csS[1] && r.bitCnt >= ADDR_BITS)
		begin
			n.replyOut = r.replyShift[15];
			n.replyShift = {r.replyShift[14:0], 1'b0};
		end

		// Register writes
		if (doWrite)
		begin
			for (int k = 0; k < 7; k++)
				if (r.addr == TX_ADDR[k])
					n.txWords[k] = wrData;
			if (r.addr == TX_ADDR[0] && wrData[1:0] != r.txTc)
			begin
				if (wrData[1:0] == r.txTc + 2'h1 && !r.txPendValid)
				begin
					n.txTc = wrData[1:0];
					n.txPend = packBlock({r.txWords[6:1], wrData});
					n.txPendBits = sizeOf(wrData[7:0]);
					n.txPendValid = 1'b1;
				end
				else
					setBits[ST_EVENT] = 1'b1;
			end
			if (r.addr == ADDR_RX_CTRL)
			begin
				n.rxCtrl = wrData;
				// Counter advance only counts when flow control is on
				if (wrData[RXC_FLOW_BIT] && wrData[1:0] == r.hostTc + 2'h1)
				begin
					n.hostTc = wrData[1:0];
					n.credit = 1'b1;
					n.xferBits = sizeOf(wrData[7:0]);
					n.rxUnitCtrl = wrData[7:2];
				end
			end
			if (r.addr == ADDR_MODE)
				n.modeCtrl = wrData;
			if (r.addr == ADDR_IRQ_MASK)
				n.irqMask = wrData;
		end

		// Burst start on any mode change
		newMode = mode_t'(n.modeCtrl[1:0]);
		modeChange = n.modeCtrl[1:0] != r.modeCtrl[1:0];
		if (modeChange)
		begin
			// Size latched at burst start, reloaded by each flow credit; timed transfers never under eight bits
			n.xferBits = sizeOf(n.rxCtrl[7:0]);
			if (!n.rxCtrl[RXC_FLOW_BIT] && n.xferBits < MIN_TIMED_BITS)
				n.xferBits = MIN_TIMED_BITS;
			n.rxUnitCtrl = n.rxCtrl[7:2];
			n.rxTc = '0;
			n.hostTc = '0;
			n.credit = 1'b0;
			n.fifoCnt = '0;
			n.asmCnt = '0;
			if (newMode == MODE_IDLE)
			begin
				n.txTc = '0;
				n.txPendValid = 1'b0;
			end
			unique case (newMode)
				MODE_IDLE: n.st = S_IDLE;
				MODE_RX: n.st = S_RX_SEARCH;
				MODE_TX: n.st = n.modeCtrl[MODE_TRIG_BIT] ? S_TX_WAIT : S_TX_RUN;
				MODE_CS: n.st = n.modeCtrl[MODE_TRIG_BIT] ? S_CS_WAIT : S_CS_SENSE;
			endcase
			n.csTimer = csStart();
			n.rssiWin = '0;
			n.rssiSum = '0;
		end
		else
		begin
			unique case (r.st)
				S_IDLE: ;
				S_RX_SEARCH:
					if (rxFeed.syncFound)
					begin
						n.st = S_RX_DATA;
						setBits[ST_FSYNC] = 1'b1;
					end
				S_RX_DATA: ;
				S_TX_WAIT:
					if (trigHit)
						n.st = S_TX_RUN;
				S_CS_WAIT:
					// Receiving while waiting; no sensing before the trigger
					if (rxFeed.syncFound)
					begin
						n.st = S_RX_DATA;
						n.modeCtrl[1:0] = MODE_RX;
						setBits[ST_CS_SYNC] = 1'b1;
						setBits[ST_FSYNC] = 1'b1;
					end
					else if (trigHit)
					begin
						n.st = S_CS_SENSE;
						n.csTimer = csStart();
						n.rssiWin = '0;
						n.rssiSum = '0;
					end
				S_CS_SENSE:
				begin
					// Moving window over the signal strength samples
					if (rxFeed.rssiValid)
					begin
						n.rssiWin = {r.rssiWin[6:0], rxFeed.rssi};
						n.rssiSum = r.rssiSum + {3'h0, rxFeed.rssi} - {3'h0, r.rssiWin[7]};
					end
					if (rxFeed.syncFound)
					begin
						n.st = S_RX_DATA;
						n.modeCtrl[1:0] = MODE_RX;
						n.txPendValid = 1'b0;
						setBits[ST_CS_SYNC] = 1'b1;
						setBits[ST_FSYNC] = 1'b1;
					end
					else if (avg > {3'h0, CS_THRESHOLD})
					begin
						n.st = S_RX_SEARCH;
						n.modeCtrl[1:0] = MODE_RX;
						n.txPendValid = 1'b0;
						setBits[ST_CS_BUSY] = 1'b1;
					end
					else if (r.csTimer == 12'h001)
					begin
						n.st = S_TX_RUN;
						setBits[ST_CS_CLEAR] = 1'b1;
					end
					else
						n.csTimer = r.csTimer - 12'h001;
				end
				S_TX_RUN: ;
			endcase
		end

		// Assemble received bits into transfer blocks
		if (r.st == S_RX_DATA && !modeChange && rxFeed.bitValid)
		begin
			n.asmData[r.asmCnt] = rxFeed.bitVal;
			n.asmCnt = nextCnt;
			if (nextCnt >= r.xferBits)
			begin
				n.asmCnt = '0;
				if (r.fifoCnt != 2'h2)
					push = 1'b1;
				else
					setBits[ST_EVENT] = 1'b1;
			end
		end

		// Release a buffered block into the rx words
		if (r.fifoCnt != 2'h0 && !modeChange)
		begin
			if (flowOn ? r.credit : r.gapCnt == 8'h00)
				pop = 1'b1;
		end
		if (r.gapCnt != 8'h00)
			n.gapCnt = r.gapCnt - 8'h01;
		if (pop)
		begin
			n.rxTc = r.rxTc + 2'h1;
			n.rxWords[0] = {popEntry[7:0], popEntry[109:104], r.rxTc + 2'h1};
			for (int k = 1; k < 7; k++)
				n.rxWords[k] = popEntry[8 + 16 * (k - 1) +: 16];
			n.fifoRd = ~r.fifoRd;
			n.credit = 1'b0;
			n.gapCnt = RX_GAP_LOAD;
			setBits[ST_READY] = 1'b1;
		end
		if (push)
		begin
			n.fifoData[r.fifoWr] = {r.rxUnitCtrl, n.asmData};
			n.fifoWr = ~r.fifoWr;
		end
		if (!modeChange)
			n.fifoCnt = r.fifoCnt + {1'b0, push} - {1'b0, pop};

		// Transmit serialiser and test patterns
		if (r.st == S_TX_RUN && !modeChange && r.txLeft == 7'h00 && r.txPendValid)
		begin
			n.txShift = r.txPend;
			n.txLeft = r.txPendBits;
			n.txPendValid = 1'b0;
			setBits[ST_READY] = 1'b1;
		end
		if (r.st == S_TX_RUN && modBitReq)
		begin
			unique case (test_t'(r.modeCtrl[MODE_TEST_LSB +: 2]))
				TEST_PRBS:
				begin
					n.tx.bitVal = r.lfsr[8];
					n.tx.bitValid = 1'b1;
					n.lfsr = {r.lfsr[7:0], r.lfsr[8] ^ r.lfsr[4]};
				end
				TEST_PREAMBLE:
				begin
					n.tx.bitVal = r.preambleBit;
					n.tx.bitValid = 1'b1;
					n.preambleBit = ~r.preambleBit;
				end
				TEST_NONE, TEST_EYE:
					if (r.txLeft != 7'h00)
					begin
						n.tx.bitVal = r.txShift[0];
						n.tx.bitValid = 1'b1;
						n.txShift = r.txShift >> 1;
						n.txLeft = r.txLeft - 7'h01;
					end
			endcase
		end
		if (r.st != S_TX_RUN)
			n.txLeft = '0;
		// Ramp and GPIO events bracket the modulation when enabled
		n.tx.rampOn = n.st == S_TX_RUN && n.modeCtrl[MODE_SEQ_BIT];
		n.tx.gpioOn = n.st == S_TX_RUN && n.modeCtrl[MODE_SEQ_BIT];

		// Eye test outputs
		n.xtalDiv = r.xtalDiv + 8'h01;
		if (r.xtalDiv == XTAL_TRIG_DIV - 8'h01)
			n.xtalDiv = '0;
		if (test_t'(r.modeCtrl[MODE_TEST_LSB +: 2]) == TEST_EYE && r.st != S_TX_RUN)
		begin
			if (rxFeed.filtValid)
				n.modA = rxFeed.filtSample;
			n.modB = r.xtalDiv == 8'h00;
		end
		else
		begin
			n.modA = {8{r.tx.bitVal}};
			n.modB = 1'b0;
		end

		// Status flags: a set in the clearing cycle wins
		if (clearFlags)
			n.status = r.status & (16'h0001 << ST_PRG);
		n.status = n.status | setBits;
		n.status[ST_PRG] = n.st == S_IDLE;
		n.status[ST_IRQ] = 1'b0;
		n.interrupt_request_line = ~((|(n.status[14:0] & n.irqMask[14:0])) & n.irqMask[ST_IRQ]);
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			r <= '0;
			r.csS <= 2'h3;
			r.sclkPrev <= 1'b0;
			r.rxCtrl <= RX_CTRL_RESET;
			r.irqMask <= IRQ_MASK_RESET;
			r.status <= STATUS_RESET;
			r.interrupt_request_line <= 1'b1;
			r.st <= S_IDLE;
			r.lfsr <= PRBS_SEED;
			r.xferBits <= MIN_TIMED_BITS;
		end
		else
			r <= n;
	end

	// Outputs straight from the state register
	assign hostReplyData = r.replyOut;
	assign interruptRequestLineN = r.interrupt_request_line;
	assign txOut = r.tx;
	assign modulatorOutputA = r.modA;
	assign modulatorOutputB = r.modB;
endmodule

// [dv/half_duplex_modem_burst_control_bench.sv]
// Self-checking bench for the modem burst controller
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
		begin \
			errors++; \
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
		end \
	end
module half_duplex_modem_burst_control_bench;
	import burst_ctrl_pkg::*;
	logic clk;
	logic reset_n;
	host_bus_in_t hostIn;
	logic hostReplyData;
	logic interruptRequestLineN;
	logic txTriggerPin;
	rx_feed_t rxFeed;
	logic modBitReq;
	tx_out_t txOut;
	logic [7:0] modulatorOutputA;
	logic modulatorOutputB;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [15:0] q;
	logic [7:0] tb = 8'h3c;
	logic v;
	logic b;

	modem_burst_ctrl modem_burst_ctrl_i (.clk(clk), .reset_n(reset_n), .hostIn(hostIn),
		.hostReplyData(hostReplyData), .interruptRequestLineN(interruptRequestLineN),
		.txTriggerPin(txTriggerPin), .rxFeed(rxFeed), .modBitReq(modBitReq), .txOut(txOut),
		.modulatorOutputA(modulatorOutputA), .modulatorOutputB(modulatorOutputB));
	host_serial_model host_serial_model_i (.clk(clk), .hostIn(hostIn),
		.hostReplyData(hostReplyData));

	// Clock and hang limit
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 50000)
		begin
			errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic [7:0] a, input logic [15:0] d);
		host_serial_model_i.xfer(a, d, q);
	endtask
	// Received bit, byte LSB first, and single-cycle feed pulses
	task automatic rbit(input logic bv);
		@(posedge clk);
		rxFeed.bitValid <= 1'b1;
		rxFeed.bitVal <= bv;
		@(posedge clk);
		rxFeed.bitValid <= 1'b0;
	endtask
	task automatic rbyte(input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			rbit(d[i]);
	endtask
	task automatic sync();
		@(posedge clk);
		rxFeed.syncFound <= 1'b1;
		@(posedge clk);
		rxFeed.syncFound <= 1'b0;
	endtask
	task automatic rssi(input logic [7:0] r);
		@(posedge clk);
		rxFeed.rssiValid <= 1'b1;
		rxFeed.rssi <= r;
		@(posedge clk);
		rxFeed.rssiValid <= 1'b0;
	endtask
	// One modulator request; answer looked for over three cycles
	task automatic bitreq();
		@(posedge clk);
		modBitReq <= 1'b1;
		@(posedge clk);
		modBitReq <= 1'b0;
		v = 1'b0;
		repeat (3)
		begin
			#1;
			if (txOut.bitValid === 1'b1)
			begin
				v = 1'b1;
				b = txOut.bitVal;
			end
			@(posedge clk);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Main sequence
	initial
	begin
		reset_n = 1'b0;
		txTriggerPin = 1'b0;
		rxFeed = '0;
		modBitReq = 1'b0;
		wait_clk(4);
		reset_n <= 1'b1;
		wait_clk(3);
		bus(ADDR_STATUS, 16'h0000);
		`CHK("status idle", 16'h0001, q)
		bus(8'h00, 16'h0000);
		`CHK("unmapped read", 16'h0000, q)
		bus(TX_ADDR[1], 16'hffff);
		bus(TX_ADDR[0], 16'h3c85);
		bus(ADDR_STATUS, 16'h0000);
		`CHK("status kept", 16'h0001, q)
		bus(ADDR_MODE, 16'h0002);
		for (int i = 0; i < 8; i++)
		begin
			bitreq();
			`CHK("tx bit", {1'b1, tb[i]}, {v, b})
		end
		`CHK("ramp off", 2'b00, {txOut.rampOn, txOut.gpioOn})
		bitreq();
		`CHK("tx empty", 1'b0, v)
		bus(ADDR_MODE, 16'h0000);
		bus(TX_ADDR[0], 16'h3c86);
		bus(ADDR_STATUS, 16'h0000);
		`CHK("seq event", 1'b1, q[ST_EVENT])
		bus(ADDR_STATUS, 16'h0000);
		`CHK("event clear", 1'b0, q[ST_EVENT])
		// Timed receive, raw byte units, same choice all burst
		bus(ADDR_RX_CTRL, 16'h0084);
		bus(ADDR_MODE, 16'h0001);
		rbyte(8'h77);
		wait_clk(250);
		bus(ADDR_STATUS, 16'h0000);
		`CHK("no rx early", 1'b0, q[ST_READY])
		sync();
		rbyte(8'ha5);
		wait_clk(250);
		bus(ADDR_STATUS, 16'h0000);
		`CHK("rx ready", 2'b11, {q[ST_FSYNC], q[ST_READY]})
		bus(RX_ADDR[0], 16'h0000);
		`CHK("rx word0", 16'ha585, q)
		rbyte(8'h5a);
		wait_clk(250);
		`CHK("irq masked", 1'b1, interruptRequestLineN)
		bus(ADDR_IRQ_MASK, 16'h8002);
		`CHK("irq late mask", 1'b0, interruptRequestLineN)
		bus(RX_ADDR[0], 16'h0000);
		`CHK("rx word0 next", 16'h5a86, q)
		bus(ADDR_STATUS, 16'h0000);
		`CHK("irq cleared", 1'b1, interruptRequestLineN)
		// Mask still open: each timed release pulls the interrupt outside a frame
		for (int k = 3; k < 5; k++)
		begin
			rbyte(8'h30);
			wait_clk(250);
			`CHK("irq on ready", 1'b0, interruptRequestLineN)
			bus(RX_ADDR[0], 16'h0000);
			`CHK("rx count wrap", {8'h30, 6'h21, 2'(k)}, q)
		end
		bus(ADDR_STATUS, 16'h0000);
		`CHK("rx count ready", 1'b1, q[ST_READY])
		bus(ADDR_IRQ_MASK, 16'h0000);
		// Flow-controlled receive
		bus(ADDR_MODE, 16'h0000);
		bus(ADDR_RX_CTRL, 16'h0184);
		bus(ADDR_MODE, 16'h0001);
		sync();
		rbyte(8'h96);
		wait_clk(250);
		bus(ADDR_STATUS, 16'h0000);
		`CHK("rx held", 1'b0, q[ST_READY])
		bus(ADDR_RX_CTRL, 16'h0185);
		bus(ADDR_STATUS, 16'h0000);
		`CHK("rx released", 1'b1, q[ST_READY])
		bus(RX_ADDR[0], 16'h0000);
		`CHK("rx word0 flow", 16'h9685, q)
		// Carrier sense: busy channel, then sync during sensing
		bus(ADDR_MODE, 16'h0000);
		bus(ADDR_MODE, 16'h0003);
		repeat (8) rssi(8'hff);
		bus(ADDR_STATUS, 16'h0000);
		`CHK("cs busy", 3'b001, {q[ST_CS_CLEAR], q[ST_CS_SYNC], q[ST_CS_BUSY]})
		sync();
		bus(ADDR_STATUS, 16'h0000);
		`CHK("search after busy", 1'b1, q[ST_FSYNC])
		bus(ADDR_MODE, 16'h0000);
		bus(ADDR_MODE, 16'h0003);
		sync();
		bus(ADDR_STATUS, 16'h0000);
		`CHK("cs sync", 3'b010, {q[ST_CS_CLEAR], q[ST_CS_SYNC], q[ST_CS_BUSY]})
		// Trigger, sensing, sequence and preamble together
		bus(ADDR_MODE, 16'h0000);
		bus(ADDR_MODE, 16'h00f7);
		wait_clk(4200);
		bus(ADDR_STATUS, 16'h0000);
		`CHK("sense after trigger", 1'b0, q[ST_CS_CLEAR])
		txTriggerPin <= 1'b1;
		wait_clk(4200);
		bus(ADDR_STATUS, 16'h0000);
		`CHK("cs clear", 3'b100, {q[ST_CS_CLEAR], q[ST_CS_SYNC], q[ST_CS_BUSY]})
		`CHK("ramp on", 2'b11, {txOut.rampOn, txOut.gpioOn})
		for (int i = 0; i < 4; i++)
		begin
			bitreq();
			`CHK("preamble bit", {1'b1, i[0]}, {v, b})
		end
		bus(ADDR_MODE, 16'h0000);
		txTriggerPin <= 1'b0;
		bus(ADDR_MODE, 16'h0022);
		bitreq();
		`CHK("prbs bit", 1'b1, v)
		// Eye test outputs
		bus(ADDR_MODE, 16'h0000);
		bus(ADDR_MODE, 16'h0011);
		@(posedge clk);
		rxFeed.filtValid <= 1'b1;
		rxFeed.filtSample <= 8'h5a;
		@(posedge clk);
		rxFeed.filtValid <= 1'b0;
		wait_clk(3);
		#1;
		`CHK("eye sample", 8'h5a, modulatorOutputA)
		v = 1'b0;
		repeat (20)
		begin
			@(posedge clk);
			#1;
			if (modulatorOutputB === 1'b1)
				v = 1'b1;
		end
		`CHK("eye trigger", 1'b1, v)
		complete_run();
	end
endmodule

// [dv/host_serial_model.sv]
// Host side of the serial control bus, one 24-bit frame per call
`timescale 1ns/1ps
module host_serial_model
(
	input wire logic clk, // Clock
	output burst_ctrl_pkg::host_bus_in_t hostIn, // Serial pins
	input wire logic hostReplyData // Read data
);
	import burst_ctrl_pkg::*;
	localparam int HALF = 6;
	initial hostIn = '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};
	// Address then data MSB first; reply taken at each data rise
	task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		logic [23:0] f;
		f = {a, d};
		q = 16'h0000;
		@(posedge clk);
		hostIn.csN <= 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			hostIn.sdi <= f[i];
			repeat (HALF) @(posedge clk);
			hostIn.sclk <= 1'b1;
			if (i < 16)
				q[i] = hostReplyData;
			repeat (HALF) @(posedge clk);
			hostIn.sclk <= 1'b0;
		end
		repeat (HALF) @(posedge clk);
		hostIn.csN <= 1'b1;
		hostIn.sdi <= ~f[0];
		repeat (HALF) @(posedge clk);
	endtask
endmodule

// [dv/modem_burst_ctrl_props.sv]
// Port checker for the modem burst controller
`timescale 1ns/1ps
module modem_burst_ctrl_props
(
	input wire logic clk, // Clock
	input wire logic reset_n, // Reset
	input wire burst_ctrl_pkg::host_bus_in_t hostIn, // Serial pins
	input wire logic hostReplyData, // Read data
	input wire logic interruptRequestLineN, // Interrupt
	input wire logic modBitReq, // Bit request
	input wire burst_ctrl_pkg::tx_out_t txOut, // Modulator feed
	input wire logic [7:0] modulatorOutputA, // Output A
	input wire logic modulatorOutputB // Output B
);
	import burst_ctrl_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Outputs quiet around reset release
	sequence outsQuiet;
		!hostReplyData && txOut == '0 && modulatorOutputA == 8'h00 && !modulatorOutputB;
	endsequence
	// One trigger pulse followed by its low stretch
	sequence eyeBeat;
		modulatorOutputB ##1 !modulatorOutputB;
	endsequence
	chk_reset_irq_idle: assert property ($rose(reset_n) |-> interruptRequestLineN[*2])
		else $error("interrupt active after reset");
	chk_reset_tx_quiet: assert property ($rose(reset_n) |-> outsQuiet ##1 outsQuiet)
		else $error("outputs busy after reset");
	chk_bit_answer: assert property (txOut.bitValid |-> $past(modBitReq) || $past(modBitReq, 2))
		else $error("bit answered without request");
	chk_bit_single: assert property (txOut.bitValid && !modBitReq |=> !txOut.bitValid)
		else $error("bit answer longer than one cycle");
	chk_eye_spacing: assert property (eyeBeat |-> !modulatorOutputB[*7])
		else $error("eye trigger pulses too close");
	chk_irq_clear_frame: assert property ($rose(interruptRequestLineN) |-> !hostIn.csN)
		else $error("interrupt released outside a host frame");
	chk_irq_hold: assert property ($fell(interruptRequestLineN) && hostIn.csN
		|=> !interruptRequestLineN)
		else $error("interrupt dropped at once");
	chk_ramp_gpio_pair: assert property (txOut.rampOn == txOut.gpioOn)
		else $error("ramp and switch events disagree");
endmodule

bind modem_burst_ctrl modem_burst_ctrl_props modem_burst_ctrl_props_i (.clk(clk),
	.reset_n(reset_n), .hostIn(hostIn), .hostReplyData(hostReplyData),
	.interruptRequestLineN(interruptRequestLineN), .modBitReq(modBitReq), .txOut(txOut),
	.modulatorOutputA(modulatorOutputA), .modulatorOutputB(modulatorOutputB));
